// [rtl/cig_regs.sv]
// Purpose: Cache identification register group of the processor core.
// Assumes: Core-side register port on REF_CLK, one access per cycle.
// Notes:   Answers are registered, one cycle after the request.
//          Faults and stores answer with zero data.
//          Cache presence and size are build-time parameters.
//          Every access is answered, a faulting one too.
`timescale 1ns/1ps
`default_nettype none
module cig_regs
   import cig_pkg::*;
#(
   parameter bit DCACHE_PRESENT = 1'b1, // Data cache built
   parameter bit ICACHE_PRESENT = 1'b1, // Instruction cache built
   parameter logic [2:0] DCACHE_SIZE = 3'h4, // Data size code, 0 is 4 KB
   parameter logic [2:0] ICACHE_SIZE = 3'h4 // Instruction size code
)(
   input wire logic REF_CLK, // Core clock
   input wire logic NRST, // Asynchronous reset, active low
   input wire logic REQ_VALID, // Register access this cycle
   input wire logic REQ_WRITE, // One for store, zero for load
   input wire logic REQ_PRIV, // Access is privileged
   input wire logic [31:0] REQ_ADDR, // Byte address
   input wire logic [31:0] REQ_WDATA, // Store data
   output logic RSP_VALID, // Answer strobe
   output logic [31:0] RSP_RDATA, // Load data
   output logic RSP_FAULT, // Bus error fault for the access
   output logic SEL_INSTR // Current selection, one is instruction
);
   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   cig_dec_if dec_bus (); // Request and its decode

   // Request fields handed to the decoder
   assign dec_bus.req_valid = REQ_VALID;
   assign dec_bus.req_priv = REQ_PRIV;
   assign dec_bus.req_addr = REQ_ADDR;

   // The decoder only matches; every register lives here
   cig_decode u_decode (
      .dec (dec_bus.decoder)
   );

   // Decode must flag every unprivileged access
   a_fault_decode: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (REQ_VALID && !REQ_PRIV) |-> dec_bus.fault)
      else $error("unprivileged access not flagged by decode");

   // ----------------------------------------------------------------
   // Selection state
   // ----------------------------------------------------------------
   logic sel_q; // Instruction-not-data select
   logic sel_d; // Next select
   logic sel_wr; // Accepted store to the selection register

   // Stores that fault never change the selection
   // A refused store is still answered, it only loses its data
   assign sel_wr = dec_bus.hit_sel && REQ_WRITE && !dec_bus.fault;

   // Only bit 0 is kept; level and reserved bits are dropped
   always_comb begin
      sel_d = sel_q;
      if (sel_wr) begin
         sel_d = REQ_WDATA[CIG_SEL_IND_BIT];
      end
   end

   // Reset to the data cache so the geometry word is defined at once
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         sel_q <= 1'b0;
      end else begin
         sel_q <= sel_d;
      end
   end

   // ----------------------------------------------------------------
   // Geometry word
   // ----------------------------------------------------------------
   logic [31:0] geom_word; // Geometry of the selected cache

   cig_geometry #(
      .DCACHE_PRESENT (DCACHE_PRESENT),
      .ICACHE_PRESENT (ICACHE_PRESENT),
      .DCACHE_SIZE (DCACHE_SIZE),
      .ICACHE_SIZE (ICACHE_SIZE)
   ) u_geometry (
      .sel_instr (sel_q),
      .geom_word (geom_word)
   );

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   logic [31:0] sel_word; // Selection register as read
   logic [31:0] rdata_d; // Next load data

   // Level and reserved fields are constants, so they read zero
   assign sel_word = {CIG_SEL_RSV, CIG_SEL_LEVEL, sel_q};

   // Faulting loads return zero so no identification data leaks
   // Stores to the read-only words are dropped without a fault
   always_comb begin
      rdata_d = CIG_ZERO_WORD;
      if (dec_bus.fault || REQ_WRITE) begin
         rdata_d = CIG_ZERO_WORD;
      end else if (dec_bus.hit_type) begin
         rdata_d = CIG_TYPE_WORD;
      end else if (dec_bus.hit_geom) begin
         rdata_d = geom_word;
      end else if (dec_bus.hit_sel) begin
         rdata_d = sel_word;
      end
   end

   // ----------------------------------------------------------------
   // Answer registers
   // ----------------------------------------------------------------
   logic rsp_valid_q; // Answer strobe
   logic rsp_fault_q; // Fault flag of the answer
   logic [31:0] rsp_rdata_q; // Load data of the answer
   logic sel_out_q; // Registered copy of the selection

   // One answer per request, one cycle later
   // One process per answer field keeps each concern apart
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         rsp_valid_q <= 1'b0;
      end else begin
         rsp_valid_q <= REQ_VALID;
      end
   end

   // Fault flag only means something with the strobe
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         rsp_fault_q <= 1'b0;
      end else begin
         rsp_fault_q <= dec_bus.fault;
      end
   end

   // Load data; zero on idle cycles keeps the bus quiet
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         rsp_rdata_q <= CIG_ZERO_WORD;
      end else begin
         rsp_rdata_q <= rdata_d;
      end
   end

   // Selection shown outside, tracks the stored bit
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         sel_out_q <= 1'b0;
      end else begin
         sel_out_q <= sel_d;
      end
   end

   // Outputs come straight from the answer flops
   assign RSP_VALID = rsp_valid_q;
   assign RSP_FAULT = rsp_fault_q;
   assign RSP_RDATA = rsp_rdata_q;
   assign SEL_INSTR = sel_out_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Load data checks look one cycle after a good load, while its answer stands,
   // and hold the registered outputs against the fixed field values.
   // Helpers describing the previous request
   logic p_load; // Previous cycle held a good load
   logic p_type; // It addressed the type word
   logic p_geom; // It addressed the geometry word
   logic p_sel; // It addressed the selection register

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         p_load <= 1'b0;
         p_type <= 1'b0;
         p_geom <= 1'b0;
         p_sel <= 1'b0;
      end else begin
         p_load <= REQ_VALID && !REQ_WRITE && !dec_bus.fault;
         p_type <= dec_bus.hit_type;
         p_geom <= dec_bus.hit_geom;
         p_sel <= dec_bus.hit_sel;
      end
   end

   // Reference geometry word of one cache, built field by field
   function automatic logic [31:0] geom_ref(input logic instr);
      logic [14:0] sets; // Sets minus one
      logic [2:0] size; // Size code of that cache
      logic present; // That cache is built
      present = instr ? ICACHE_PRESENT : DCACHE_PRESENT;
      size = instr ? ICACHE_SIZE : DCACHE_SIZE;
      sets = instr ? CIG_INSTR_SETS_4K : CIG_DATA_SETS_4K;
      // The set count doubles per step, not count minus one
      sets = ((sets + 15'h0001) << size) - 15'h0001;
      geom_ref = CIG_ZERO_WORD;
      if (present) begin
         geom_ref = {instr ? CIG_INSTR_POLICY : CIG_DATA_POLICY, sets,
            instr ? CIG_INSTR_WAYS : CIG_DATA_WAYS, CIG_LINE_CODE};
      end
   endfunction : geom_ref

   logic [31:0] geom_chk; // Reference word for the cache now shown
   assign geom_chk = geom_ref(SEL_INSTR);

   // Layout version bits
   a_type_format: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (p_load && p_type) |-> RSP_RDATA[31:29] == 3'b100)
      else $error("type word format bits wrong");

   // Fixed zero and one bits of the type word
   a_type_fixed: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (p_load && p_type) |-> (RSP_RDATA[28] == 1'b0 && RSP_RDATA[15:14] == 2'b11
      && RSP_RDATA[13:4] == 10'h000))
      else $error("type word fixed bits wrong");

   // Write-back granule is eight words
   a_type_granules: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (p_load && p_type) |-> (RSP_RDATA[27:24] == 4'h3 && RSP_RDATA[23:20] == 4'h0))
      else $error("type word granule fields wrong");

   // No reservation granule, the monitor keeps no address
   a_type_reserve: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (p_load && p_type) |-> RSP_RDATA[23:20] == 4'h0)
      else $error("reservation granule not zero");

   // Smallest data line is eight words
   a_type_lines: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (p_load && p_type) |-> (RSP_RDATA[19:16] == 4'h3 && RSP_RDATA[3:0] == 4'h3))
      else $error("minimum line fields wrong");

   // Whole type word, instruction line included
   a_imin_line: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (p_load && p_type) |-> RSP_RDATA == 32'h8303c003)
      else $error("type word value wrong");

   // Geometry word belongs to the selected cache
   a_geom_follows: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (p_load && p_geom) |-> RSP_RDATA == geom_chk)
      else $error("geometry word does not match selection");

   // An absent cache reads as zero
   a_geom_absent: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (p_load && p_geom && (SEL_INSTR ? !ICACHE_PRESENT : !DCACHE_PRESENT))
      |-> RSP_RDATA == 32'h0)
      else $error("absent cache not read as zero");

   // Line code says eight words
   a_geom_line: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (p_load && p_geom && RSP_RDATA != 32'h0) |-> RSP_RDATA[2:0] == 3'h1)
      else $error("line code wrong");

   // Ways minus one
   a_geom_ways: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (p_load && p_geom && RSP_RDATA != 32'h0)
      |-> RSP_RDATA[12:3] == (SEL_INSTR ? 10'h001 : 10'h003))
      else $error("way count wrong");

   // Policy flags of the shown cache
   a_geom_policy: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (p_load && p_geom && RSP_RDATA != 32'h0)
      |-> RSP_RDATA[31:28] == (SEL_INSTR ? 4'h2 : 4'hf))
      else $error("policy bits wrong");

   // A good store sets the selection; a later store may change it again
   a_sel_write: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (REQ_VALID && REQ_WRITE && REQ_PRIV && REQ_ADDR == CIG_ADDR_SEL)
      |=> SEL_INSTR == $past(REQ_WDATA[CIG_SEL_IND_BIT]))
      else $error("selection write not kept");

   // Only bit 0 of the selection can read one
   a_sel_upper: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (p_load && p_sel) |-> RSP_RDATA[31:1] == 31'h0)
      else $error("selection upper bits not zero");

   // Unprivileged access ends in a fault
   a_unpriv_fault: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (REQ_VALID && !REQ_PRIV) |=> (RSP_VALID && RSP_FAULT && RSP_RDATA == 32'h0))
      else $error("unprivileged access completed");

   // A refused store leaves the selection
   a_unpriv_nowrite: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (REQ_VALID && REQ_WRITE && !REQ_PRIV) |=> $stable(SEL_INSTR))
      else $error("unprivileged store changed selection");

   // Set count field of the shown cache
   a_geom_sets: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (p_load && p_geom) |-> RSP_RDATA[27:13] == geom_chk[27:13])
      else $error("set count wrong");

   // Data cache fields, set count at the largest size
   a_data_geom: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (p_load && p_geom && !SEL_INSTR && DCACHE_PRESENT) |-> (RSP_RDATA[31:28] == 4'hf
      && RSP_RDATA[12:0] == 13'h0019
      && (DCACHE_SIZE != CIG_SIZE_MAX || RSP_RDATA[27:13] == 15'h01ff)))
      else $error("data cache geometry wrong");

   // Instruction cache fields, set count at the largest size
   a_instr_geom: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (p_load && p_geom && SEL_INSTR && ICACHE_PRESENT) |-> (RSP_RDATA[31:28] == 4'h2
      && RSP_RDATA[12:0] == 13'h0009
      && (ICACHE_SIZE != CIG_SIZE_MAX || RSP_RDATA[27:13] == 15'h03ff)))
      else $error("instruction cache geometry wrong");

   // Level field reads the first level
   a_sel_level: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (p_load && p_sel) |-> RSP_RDATA[3:1] == CIG_SEL_LEVEL)
      else $error("selection level not zero");

   // Reserved selection bits read zero
   a_sel_reserved: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (p_load && p_sel) |-> RSP_RDATA[31:4] == CIG_SEL_RSV)
      else $error("selection reserved bits not zero");

   // A fault never carries data
   a_fault_data: assert property (@(posedge REF_CLK) disable iff (!NRST)
      (RSP_VALID && RSP_FAULT) |-> RSP_RDATA == CIG_ZERO_WORD)
      else $error("faulting answer carries data");

   // Every access, refused or not, gets one answer
   a_answer_once: assert property (@(posedge REF_CLK) disable iff (!NRST)
      REQ_VALID |=> RSP_VALID)
      else $error("access not answered");
endmodule : cig_regs
`default_nettype wire

// [rtl/cig_pkg.sv]
// Purpose: Shared constants for the cache identification register group.
// Assumes: 32-bit register data, word aligned addresses.
// Notes:   Field layouts and fixed values are built from named pieces.
package cig_pkg;
   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [31:0] CIG_ADDR_TYPE = 32'he000ed7c; // Cache type word
   localparam logic [31:0] CIG_ADDR_GEOM = 32'he000ed80; // Cache geometry word
   localparam logic [31:0] CIG_ADDR_SEL = 32'he000ed84; // Cache selection register

   // ----------------------------------------------------------------
   // Cache type word fields
   // ----------------------------------------------------------------
   localparam logic [2:0] CIG_TYPE_FORMAT = 3'h4; // Layout version, bits 31:29
   localparam logic [0:0] CIG_TYPE_RSV28 = 1'h0; // Bit 28 reads zero
   localparam logic [3:0] CIG_WB_GRANULE = 4'h3; // Eight-word write-back granule
   localparam logic [3:0] CIG_RSV_GRANULE = 4'h0; // Monitor holds no address
   localparam logic [3:0] CIG_MIN_DATA_LINE = 4'h3; // Eight words
   localparam logic [1:0] CIG_TYPE_ONES = 2'h3; // Bits 15:14 read one
   localparam logic [9:0] CIG_TYPE_RSV13_4 = 10'h000; // Bits 13:4 read zero
   localparam logic [3:0] CIG_MIN_INSTR_LINE = 4'h3; // Eight words
   localparam logic [31:0] CIG_TYPE_WORD = {CIG_TYPE_FORMAT, CIG_TYPE_RSV28,
      CIG_WB_GRANULE, CIG_RSV_GRANULE, CIG_MIN_DATA_LINE, CIG_TYPE_ONES,
      CIG_TYPE_RSV13_4, CIG_MIN_INSTR_LINE};

   // ----------------------------------------------------------------
   // Cache geometry word fields
   // ----------------------------------------------------------------
   localparam int CIG_POL_LSB = 28; // Policy nibble position
   localparam int CIG_SETS_LSB = 13; // Set count field position
   localparam int CIG_WAYS_LSB = 3; // Way count field position
   localparam logic [3:0] CIG_DATA_POLICY = 4'hf; // WT, WB, RA, WA
   localparam logic [3:0] CIG_INSTR_POLICY = 4'h2; // Read-allocate only
   localparam logic [14:0] CIG_DATA_SETS_4K = 15'h001f; // Sets minus one at 4 KB
   localparam logic [14:0] CIG_INSTR_SETS_4K = 15'h003f; // Sets minus one at 4 KB
   localparam logic [9:0] CIG_DATA_WAYS = 10'h003; // Four ways
   localparam logic [9:0] CIG_INSTR_WAYS = 10'h001; // Two ways
   localparam logic [2:0] CIG_LINE_CODE = 3'h1; // Eight words per line
   localparam logic [2:0] CIG_SIZE_MAX = 3'h4; // 64 KB size step
   localparam logic [31:0] CIG_ZERO_WORD = 32'h00000000; // Absent cache

   // ----------------------------------------------------------------
   // Cache selection register fields
   // ----------------------------------------------------------------
   localparam int CIG_SEL_IND_BIT = 0; // Instruction-not-data select bit
   localparam logic [2:0] CIG_SEL_LEVEL = 3'h0; // First level only
   localparam logic [27:0] CIG_SEL_RSV = 28'h0000000; // Reserved upper bits
endpackage : cig_pkg

// [rtl/cig_dec_if.sv]
// Purpose: Carries a register request and its decode between modules.
// Assumes: Single clock, decode is combinational.
// Notes:   Requester drives the request, decoder returns the hits.
`timescale 1ns/1ps
`default_nettype none
interface cig_dec_if;
   logic req_valid; // Access presented this cycle
   logic req_priv; // Access is privileged
   logic [31:0] req_addr; // Byte address
   logic hit_type; // Cache type word addressed
   logic hit_geom; // Cache geometry word addressed
   logic hit_sel; // Cache selection register addressed
   logic fault; // Access must end in a bus error

   modport requester (output req_valid, req_priv, req_addr,
      input hit_type, hit_geom, hit_sel, fault);
   modport decoder (input req_valid, req_priv, req_addr,
      output hit_type, hit_geom, hit_sel, fault);
endinterface : cig_dec_if
`default_nettype wire

// [rtl/cig_decode.sv]
// Purpose: Address and privilege decode for the identification registers.
// Assumes: Request fields are stable during the cycle they are valid.
// Notes:   Purely combinational; the top registers every answer.
`timescale 1ns/1ps
`default_nettype none
module cig_decode
   import cig_pkg::*;
(
   cig_dec_if.decoder dec
);
   // ----------------------------------------------------------------
   // Address match
   // ----------------------------------------------------------------
   // Whole-word compare; sub-word offsets are not mapped
   function automatic logic addr_is(input logic [31:0] a, input logic [31:0] base);
      addr_is = (a == base);
   endfunction : addr_is

   logic any_hit; // Address belongs to the group

   // Hits are qualified by valid so idle cycles never look like accesses
   always_comb begin
      dec.hit_type = dec.req_valid && addr_is(dec.req_addr, CIG_ADDR_TYPE);
      dec.hit_geom = dec.req_valid && addr_is(dec.req_addr, CIG_ADDR_GEOM);
      dec.hit_sel = dec.req_valid && addr_is(dec.req_addr, CIG_ADDR_SEL);
      any_hit = dec.hit_type || dec.hit_geom || dec.hit_sel;
      // Unprivileged or unmapped access faults
      dec.fault = dec.req_valid && (!dec.req_priv || !any_hit);
   end
endmodule : cig_decode
`default_nettype wire

// [rtl/cig_geometry.sv]
// Purpose: Builds the cache geometry word for the selected cache.
// Assumes: Size codes 0..4 stand for 4 KB..64 KB.
// Notes:   Set counts double per size step; the count is shifted, then one is taken off.
`timescale 1ns/1ps
`default_nettype none
module cig_geometry
   import cig_pkg::*;
#(
   parameter bit DCACHE_PRESENT = 1'b1, // Data cache built
   parameter bit ICACHE_PRESENT = 1'b1, // Instruction cache built
   parameter logic [2:0] DCACHE_SIZE = 3'h4, // Data cache size code
   parameter logic [2:0] ICACHE_SIZE = 3'h4 // Instruction cache size code
)(
   input wire logic sel_instr, // One selects the instruction cache
   output logic [31:0] geom_word // Geometry of the selected cache
);
   // ----------------------------------------------------------------
   // Per-cache words
   // ----------------------------------------------------------------
   logic [14:0] dsets; // Data sets minus one
   logic [14:0] isets; // Instruction sets minus one
   logic [31:0] dword; // Data cache geometry
   logic [31:0] iword; // Instruction cache geometry
   localparam logic [14:0] SETS_ONE = 15'h0001; // Turns a minus-one count into a count

   // Policy, sets, ways and line code per cache
   always_comb begin
      // Shifting count minus one would leave the low bits zero
      dsets = ((CIG_DATA_SETS_4K + SETS_ONE) << DCACHE_SIZE) - SETS_ONE;
      isets = ((CIG_INSTR_SETS_4K + SETS_ONE) << ICACHE_SIZE) - SETS_ONE;
      dword = {CIG_DATA_POLICY, dsets, CIG_DATA_WAYS, CIG_LINE_CODE};
      iword = {CIG_INSTR_POLICY, isets, CIG_INSTR_WAYS, CIG_LINE_CODE};
      // Selection steers the word; an absent cache reads zero
      if (sel_instr) begin
         geom_word = ICACHE_PRESENT ? iword : CIG_ZERO_WORD;
      end else begin
         geom_word = DCACHE_PRESENT ? dword : CIG_ZERO_WORD;
      end
   end
endmodule : cig_geometry
`default_nettype wire

// [verification/cig_regs_tb.sv]
// Purpose: Self-checking bench for the cache identification register group.
// Assumes: One access per cycle, answers one cycle later, inputs set at falling edge.
// Notes:   Instance b has a small data cache and no instruction cache.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import cig_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals and bench state
   // ----------------------------------------------------------------
   typedef struct {
      logic [31:0] a; // Expected load data, instance a
      logic [31:0] b; // Expected load data, instance b
      logic fault; // Expected bus error
      logic sel; // Expected selection after the access
   } cig_tb_note_t;
   logic ref_clk = 1'b0; // Core clock
   logic nrst = 1'b0; // Reset, active low
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic req_priv = 1'b0;
   logic [31:0] req_addr = 32'h00000000;
   logic [31:0] req_wdata = 32'h00000000;
   logic rsp_valid_a, rsp_fault_a, sel_instr_a, rsp_valid_b, rsp_fault_b, sel_instr_b;
   logic [31:0] rsp_rdata_a, rsp_rdata_b;
   cig_tb_note_t notes[$]; // Expected answers, oldest first
   cig_tb_note_t note; // Note under comparison
   logic sel_m = 1'b0; // Bench copy of the selection
   logic valid_m = 1'b0; // Expected answer strobe
   logic [31:0] rng_state = 32'd7796; // Xorshift state
   int n_mismatch = 0;
   int comparisons = 0;
   // Unmapped neighbours on both sides catch a loose decode
   logic [31:0] addr_tab [5] = '{CIG_ADDR_TYPE, CIG_ADDR_GEOM, CIG_ADDR_SEL,
      CIG_ADDR_SEL + 32'h00000004, CIG_ADDR_TYPE - 32'h00000004};

   // ----------------------------------------------------------------
   // Devices under test
   // ----------------------------------------------------------------
   cig_regs i_cig_regs (.REF_CLK(ref_clk), .NRST(nrst), .REQ_VALID(req_valid),
      .REQ_WRITE(req_write), .REQ_PRIV(req_priv), .REQ_ADDR(req_addr),
      .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid_a), .RSP_RDATA(rsp_rdata_a),
      .RSP_FAULT(rsp_fault_a), .SEL_INSTR(sel_instr_a));
   cig_regs #(.ICACHE_PRESENT(1'b0), .DCACHE_SIZE(3'h0)) i_cig_regs_b (.REF_CLK(ref_clk),
      .NRST(nrst), .REQ_VALID(req_valid), .REQ_WRITE(req_write), .REQ_PRIV(req_priv),
      .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid_b),
      .RSP_RDATA(rsp_rdata_b), .RSP_FAULT(rsp_fault_b), .SEL_INSTR(sel_instr_b));

   // Clock, 10 ns period
   always #5 ref_clk = ~ref_clk;

   // A request taken at one edge is answered at the next
   always @(posedge ref_clk) valid_m <= req_valid;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function logic [31:0] next_rand();
      rng_state = rng_state ^ (rng_state << 13);
      rng_state = rng_state ^ (rng_state >> 17);
      rng_state = rng_state ^ (rng_state << 5);
      return rng_state;
   endfunction : next_rand

   // Geometry word worked out from the field layout; sets double per size step
   function automatic logic [31:0] geom_exp(input logic present, input logic instr,
      input logic [2:0] size);
      logic [14:0] sets;
      if (!present) begin
         return 32'h00000000;
      end
      sets = instr ? ((15'h0040 << size) - 15'h0001) : ((15'h0020 << size) - 15'h0001);
      return instr ? {4'h2, sets, 10'h001, 3'h1} : {4'hf, sets, 10'h003, 3'h1};
   endfunction : geom_exp

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One access; the expectation is noted as the request is driven
   task automatic access(input logic wr, input logic priv, input logic [31:0] addr,
      input logic [31:0] wdata);
      cig_tb_note_t n;
      logic mapped;
      @(negedge ref_clk);
      req_valid = 1'b1;
      req_write = wr;
      req_priv = priv;
      req_addr = addr;
      req_wdata = wdata;
      mapped = (addr == CIG_ADDR_TYPE) || (addr == CIG_ADDR_GEOM) || (addr == CIG_ADDR_SEL);
      n.fault = !(priv && mapped);
      n.a = 32'h00000000;
      n.b = 32'h00000000;
      if (!n.fault && wr && addr == CIG_ADDR_SEL) begin
         sel_m = wdata[0];
      end else if (!n.fault && !wr) begin
         if (addr == CIG_ADDR_TYPE) begin
            n.a = {3'h4, 1'h0, 4'h3, 4'h0, 4'h3, 2'h3, 10'h000, 4'h3};
         end else if (addr == CIG_ADDR_GEOM) begin
            n.a = geom_exp(1'b1, sel_m, 3'h4);
            n.b = geom_exp(!sel_m, sel_m, 3'h0);
         end else begin
            n.a = {31'h00000000, sel_m};
         end
         n.b = (addr == CIG_ADDR_GEOM) ? n.b : n.a;
      end
      n.sel = sel_m;
      notes.push_back(n);
   endtask : access

   task automatic idle(input int cycles);
      repeat (cycles) begin
         @(negedge ref_clk);
         req_valid = 1'b0;
      end
   endtask : idle

   task automatic apply_reset(input int cycles);
      @(negedge ref_clk);
      req_valid = 1'b0;
      nrst = 1'b0;
      sel_m = 1'b0;
      repeat (cycles) @(negedge ref_clk);
      nrst = 1'b1;
   endtask : apply_reset

   task automatic print_verdict();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict

   // ----------------------------------------------------------------
   // Monitor: every answer takes the oldest note
   // ----------------------------------------------------------------
   always @(negedge ref_clk) begin
      check("valid_a", {31'h0, rsp_valid_a}, {31'h0, valid_m});
      check("valid_b", {31'h0, rsp_valid_b}, {31'h0, valid_m});
      if (rsp_valid_a === 1'b1) begin
         if (notes.size() == 0) begin
            check("unexpected_answer", 32'h1, 32'h0);
         end else begin
            note = notes.pop_front();
            check("rdata_a", rsp_rdata_a, note.a);
            check("rdata_b", rsp_rdata_b, note.b);
            check("fault_a", {31'h0, rsp_fault_a}, {31'h0, note.fault});
            check("fault_b", {31'h0, rsp_fault_b}, {31'h0, note.fault});
            check("sel_a", {31'h0, sel_instr_a}, {31'h0, note.sel});
            check("sel_b", {31'h0, sel_instr_b}, {31'h0, note.sel});
         end
      end
   end

   // Watchdog; the whole run needs about 110 cycles
   initial begin
      repeat (3000) @(posedge ref_clk);
      n_mismatch++;
      print_verdict();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      apply_reset(8);
      access(1'b0, 1'b1, CIG_ADDR_SEL, 32'h0); // Reset selection is data
      access(1'b0, 1'b1, CIG_ADDR_TYPE, 32'h0);
      access(1'b0, 1'b1, CIG_ADDR_GEOM, 32'h0);
      // Junk in the level and reserved bits must be dropped
      access(1'b1, 1'b1, CIG_ADDR_SEL, next_rand() | 32'h0000000f);
      access(1'b0, 1'b1, CIG_ADDR_GEOM, 32'h0);
      access(1'b0, 1'b1, CIG_ADDR_SEL, 32'h0);
      // Unprivileged store must leave the selection alone
      access(1'b1, 1'b0, CIG_ADDR_SEL, 32'h0);
      access(1'b0, 1'b0, CIG_ADDR_GEOM, 32'h0);
      access(1'b0, 1'b1, CIG_ADDR_GEOM, 32'h0);
      access(1'b1, 1'b1, CIG_ADDR_TYPE, next_rand());
      access(1'b0, 1'b1, CIG_ADDR_TYPE, 32'h0);
      access(1'b0, 1'b1, CIG_ADDR_SEL + 32'h00000004, 32'h0);
      idle(2);
      // Reset in mid-run returns the selection to data
      apply_reset(3);
      check("sel_after_reset", {31'h0, sel_instr_a}, 32'h0);
      for (int i = 0; i < 80; i++) begin
         logic [31:0] r;
         r = next_rand();
         access(r[4], r[3:2] != 2'h0, addr_tab[r[7:5] % 5], next_rand());
      end
      idle(3);
      check("notes_left", notes.size(), 32'h0);
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
